// >>> bench/root_port_hotplug_pme_msi_regs_tb_top.sv
// self-checking bench for the root port register block
// assumes rphp_regs, the slot model and the bound checker
`timescale 1ns/10ps
module root_port_hotplug_pme_msi_regs_tb_top;
    logic        clk_sys = 1'b0, arst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, slow = 1'b0;
    logic [7:2]  cfg_addr = 6'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata_r, msi_addr_r, d, e;
    logic        bus_master_enable = 1'b1, serr_enable = 1'b1, slot_implemented = 1'b1;
    logic        dl_active_state = 1'b0, presence_detect = 1'b0, button_press_evt = 1'b0;
    logic        pme_evt = 1'b0, err_fatal_evt = 1'b0, err_nonfatal_evt = 1'b0, err_corr_evt = 1'b0;
    logic        msi_ack = 1'b0, cfg_rd_valid_r, lamp_msg_valid_r, lamp_msg_sel_r, lamp_msg_ready;
    logic        serr_r, intx_r, msi_req_r;
    logic [1:0]  lamp_msg_state_r, pw, at;
    logic [15:0] pme_req_id = 16'h0, msi_data_r;
    int          fail_count = 0, checked = 0, i;
    rphp_regs dut (.*);
    rphp_slot_model mdl (.*);
    always #2 clk_sys = ~clk_sys;
    // --------------------------------------------
    // bus and check tasks
    // --------------------------------------------
    task automatic complete_run();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang(input int k);
        if (k >= 200) begin
            fail_count++;
            $display("Error %0t: wait expired", $time);
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] w);
        @(negedge clk_sys);
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a[7:2], be, w};
        @(negedge clk_sys);
        cfg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk_sys);
        {cfg_rd, cfg_addr} = {1'b1, a[7:2]};
        @(negedge clk_sys);
        cfg_rd = 1'b0;
        chk({31'h0, cfg_rd_valid_r}, 32'h1);
        chk(cfg_rdata_r, exp);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask
    // --------------------------------------------
    // scenarios
    // --------------------------------------------
    initial begin
        void'($urandom(32'h3CB5));
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
        rd(8'h58, 32'h0);
        rd(8'h80, 32'h0000_9005);
        rd(8'h90, 32'h0000_A00D);
        rd(8'hA0, 32'hC802_0001);
        rd(8'hF0, 32'h0);
        for (int n = 0; n < 3; n++) begin
            slow = n[0];
            pw = 2'($urandom_range(3, 1));
            at = 2'($urandom_range(3, 1));
            d = ($urandom & 32'h0000_1C3F) | {pw, at, 6'h00};
            wr(8'h58, 4'h3, d);
            for (i = 0; i < 200 && mdl.cnt < 2 * n + 2; i++) @(negedge clk_sys);
            hang(i);
            chk(32'(mdl.msg_log[2 * n]), {29'h0, 1'b0, pw});
            chk(32'(mdl.msg_log[2 * n + 1]), {29'h0, 1'b1, at});
            rd(8'h58, {16'h0010, d[15:0] & 16'h13FF});
            chk({31'h0, intx_r}, {31'h0, d[5] & d[4]});
            wr(8'h58, 4'h4, 32'h0010_0000);
            rd(8'h58, {16'h0000, d[15:0] & 16'h13FF});
        end
        dl_active_state = 1'b1;
        presence_detect = 1'b1;
        pulse(button_press_evt);
        rd(8'h58, {16'h0149, d[15:0] & 16'h13FF});
        chk({31'h0, intx_r}, {31'h0, d[5] & (d[12] | d[3] | d[0])});
        wr(8'h58, 4'hC, 32'h0149_0000);
        rd(8'h58, {16'h0040, d[15:0] & 16'h13FF});
        e = $urandom;
        pme_req_id = e[15:0];
        pulse(pme_evt);
        pme_req_id = e[31:16];
        pulse(pme_evt);
        rd(8'h60, {16'h0003, e[15:0]});
        wr(8'h60, 4'h4, 32'h0001_0000);
        rd(8'h60, {16'h0001, e[31:16]});
        wr(8'h5C, 4'h3, 32'h0000_000F);
        rd(8'h5C, 32'h0000_000F);
        chk({31'h0, intx_r}, 32'h1);
        wr(8'h60, 4'h4, 32'h0001_0000);
        rd(8'h60, {16'h0000, e[31:16]});
        chk({31'h0, intx_r}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            serr_enable = (k != 3);
            @(negedge clk_sys);
            {err_fatal_evt, err_nonfatal_evt, err_corr_evt} = 3'h4 >> (k % 3);
            @(negedge clk_sys);
            {err_fatal_evt, err_nonfatal_evt, err_corr_evt} = 3'h0;
            chk({31'h0, serr_r}, {31'h0, k != 3});
        end
        e = $urandom;
        d = $urandom;
        wr(8'h84, 4'hF, e);
        wr(8'h88, 4'h3, d);
        wr(8'h80, 4'hC, 32'h0071_0000);
        rd(8'h80, 32'h0071_9005);
        rd(8'h84, e & 32'hFFFF_FFFC);
        pulse(pme_evt);
        for (i = 0; i < 200 && msi_req_r !== 1'b1; i++) @(negedge clk_sys);
        hang(i);
        chk(msi_addr_r, e & 32'hFFFF_FFFC);
        chk({16'h0, msi_data_r}, {16'h0, d[15:0]});
        chk({31'h0, intx_r}, 32'h0);
        pulse(msi_ack);
        chk({31'h0, msi_req_r}, 32'h0);
        bus_master_enable = 1'b0;
        wr(8'h60, 4'h4, 32'h0001_0000);
        pulse(pme_evt);
        repeat (3) @(negedge clk_sys);
        chk({30'h0, msi_req_r, intx_r}, 32'h0);
        wr(8'h94, 4'hF, e);
        wr(8'h94, 4'hF, ~e);
        rd(8'h94, e);
        complete_run();
    end
endmodule

// >>> bench/rphp_regs_props.sv
// port-level checker for the root port register block
// bound to every rphp_regs instance; sees only its ports
`timescale 1ns/10ps
module rphp_regs_props (
    input wire        clk_sys,
    input wire        arst_n,
    input wire        cfg_rd,
    input wire        cfg_rd_valid_r,
    input wire        serr_enable,
    input wire        bus_master_enable,
    input wire        err_fatal_evt,
    input wire        err_nonfatal_evt,
    input wire        err_corr_evt,
    input wire        serr_r,
    input wire        lamp_msg_valid_r,
    input wire        lamp_msg_sel_r,
    input wire [1:0]  lamp_msg_state_r,
    input wire        lamp_msg_ready,
    input wire        msi_req_r,
    input wire        msi_ack,
    input wire [31:0] msi_addr_r,
    input wire [15:0] msi_data_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // --------------------------------------------
    // port relations
    // --------------------------------------------
    a_read_answer: assert property (cfg_rd_valid_r == $past(cfg_rd))
        else $error("read answer not one cycle after strobe");
    a_serr_cause: assert property (serr_r |-> $past(serr_enable) &&
        ($past(err_fatal_evt) || $past(err_nonfatal_evt) || $past(err_corr_evt)))
        else $error("system error without enabled cause");
    a_serr_gate: assert property (!serr_enable |=> !serr_r)
        else $error("system error while disabled");
    a_lamp_hold: assert property (lamp_msg_valid_r && !lamp_msg_ready |=>
        lamp_msg_valid_r && $stable(lamp_msg_sel_r) && $stable(lamp_msg_state_r))
        else $error("indicator message dropped or changed");
    a_lamp_code: assert property (lamp_msg_valid_r |-> lamp_msg_state_r != 2'h0)
        else $error("reserved indicator code sent");
    a_lamp_gap: assert property (lamp_msg_valid_r && lamp_msg_ready |=> !lamp_msg_valid_r)
        else $error("indicator message not released");
    a_msi_hold: assert property (msi_req_r && !msi_ack |=>
        msi_req_r && $stable(msi_addr_r) && $stable(msi_data_r))
        else $error("msi request dropped or changed");
    a_msi_align: assert property (msi_req_r |-> msi_addr_r[1:0] == 2'h0)
        else $error("msi address not dword aligned");
    a_msi_bme: assert property ($rose(msi_req_r) |-> $past(bus_master_enable))
        else $error("msi without bus master enable");
endmodule

bind rphp_regs rphp_regs_props u_props (.*);

// >>> bench/rphp_slot_model.sv
// hot-plug slot device: takes indicator messages and logs them
// assumes the lamp handshake runs on clk_sys
`timescale 1ns/10ps
module rphp_slot_model (
    input wire       clk_sys,
    input wire       arst_n,
    input wire       slow,
    input wire       lamp_msg_valid_r,
    input wire       lamp_msg_sel_r,
    input wire [1:0] lamp_msg_state_r,
    output logic     lamp_msg_ready
);
    logic [2:0] msg_log [0:7];
    int         cnt = 0;
    // --------------------------------------------
    // accept promptly, or stall at random
    // --------------------------------------------
    initial lamp_msg_ready = 1'b0;
    always @(negedge clk_sys) begin
        lamp_msg_ready <= !slow || ($urandom_range(2) == 0);
    end
    always @(posedge clk_sys) begin
        if (arst_n && lamp_msg_valid_r && lamp_msg_ready) begin
            msg_log[cnt[2:0]] <= {lamp_msg_sel_r, lamp_msg_state_r};
            cnt <= cnt + 1;
        end
    end
endmodule

// >>> design/rphp_map.vh
// register map, field positions, reset values and constants of the root port
// hot-plug / pme / msi configuration register block
// assumes configuration cycles address whole dwords with byte enables
`ifndef RPHP_MAP_VH
`define RPHP_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define RPHP_OFS_SLOT_CONTROL    8'h58
`define RPHP_OFS_SLOT_STATUS     8'h5A
`define RPHP_OFS_ROOT_CONTROL    8'h5C
`define RPHP_OFS_ROOT_STATUS     8'h60
`define RPHP_OFS_MSI_CAP_HEADER  8'h80
`define RPHP_OFS_MSI_MSG_CONTROL 8'h82
`define RPHP_OFS_MSI_MSG_ADDRESS 8'h84
`define RPHP_OFS_MSI_MSG_DATA    8'h88
`define RPHP_OFS_SUBSYS_CAP_HDR  8'h90
`define RPHP_OFS_SUBSYSTEM_IDS   8'h94
`define RPHP_OFS_PM_CAP_HEADER   8'hA0
`define RPHP_OFS_PM_CAPABILITIES 8'hA2

// ------------------------------------------------------------
// reset and constant values
// ------------------------------------------------------------
`define RPHP_RST_SLOT_CONTROL    16'h0000
`define RPHP_RST_ROOT_CONTROL    16'h0000
`define RPHP_RST_MSI_ADDRESS     32'h00000000
`define RPHP_RST_SUBSYSTEM_IDS   32'h00000000
`define RPHP_VAL_MSI_CAP_HEADER  16'h9005
`define RPHP_VAL_SUBSYS_CAP_HDR  16'hA00D
`define RPHP_VAL_PM_CAP_HEADER   16'h0001
`define RPHP_VAL_PM_CAPS         16'hC802

// ------------------------------------------------------------
// slot control fields
// ------------------------------------------------------------
`define RPHP_SC_LINK_ACTIVE_CHANGE_IRQ_ENABLE      12
`define RPHP_SC_PWR_HI    9
`define RPHP_SC_PWR_LO    8
`define RPHP_SC_ATT_HI    7
`define RPHP_SC_ATT_LO    6
`define RPHP_SC_HPE       5
`define RPHP_SC_CCE       4
`define RPHP_SC_PDE       3
`define RPHP_SC_LATCH     2
`define RPHP_SC_PFE       1
`define RPHP_SC_ABE       0
`define RPHP_SC_WMASK     16'h13FF

// ------------------------------------------------------------
// slot status fields
// ------------------------------------------------------------
`define RPHP_SS_LINK_ACTIVE_CHANGED_FLAG      8
`define RPHP_SS_PDS       6
`define RPHP_SS_CC        4
`define RPHP_SS_PDC       3
`define RPHP_SS_ABP       0

// ------------------------------------------------------------
// root control / status, msi fields
// ------------------------------------------------------------
`define RPHP_RC_PIE       3
`define RPHP_RC_SFE       2
`define RPHP_RC_SNE       1
`define RPHP_RC_SCE       0
`define RPHP_RC_WMASK     16'h000F
`define RPHP_RS_PP        17
`define RPHP_RS_PS        16
`define RPHP_MC_MME_HI    6
`define RPHP_MC_MME_LO    4
`define RPHP_MC_EN        0
`define RPHP_MC_WMASK     16'h0071

// ------------------------------------------------------------
// indicator encodings
// ------------------------------------------------------------
`define RPHP_LAMP_RSVD    2'h0
`define RPHP_LAMP_ON      2'h1
`define RPHP_LAMP_BLINK   2'h2
`define RPHP_LAMP_OFF     2'h3
`define RPHP_LAMP_SEL_PWR 1'b0
`define RPHP_LAMP_SEL_ATT 1'b1

`endif

// >>> design/rphp_regs.v
// root port hot-plug, pme, system-error and msi configuration registers
// assumes one clock; config cycles and link events are synchronous to clk_sys
`timescale 1ns/10ps
`include "rphp_map.vh"

module rphp_regs (
    input  wire        clk_sys,
    input  wire        arst_n,
    // configuration cycles, dword address
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:2]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata_r,
    output reg         cfg_rd_valid_r,
    // command and capability register bits kept elsewhere
    input  wire        bus_master_enable,
    input  wire        serr_enable,
    input  wire        slot_implemented,
    // link and slot events
    input  wire        dl_active_state,
    input  wire        presence_detect,
    input  wire        button_press_evt,
    // indicator messages to the link partner
    output reg         lamp_msg_valid_r,
    output reg         lamp_msg_sel_r,
    output reg  [1:0]  lamp_msg_state_r,
    input  wire        lamp_msg_ready,
    // pme messages and reported errors
    input  wire        pme_evt,
    input  wire [15:0] pme_req_id,
    input  wire        err_fatal_evt,
    input  wire        err_nonfatal_evt,
    input  wire        err_corr_evt,
    output reg         serr_r,
    // interrupt delivery
    output reg         intx_r,
    output reg         msi_req_r,
    output reg  [31:0] msi_addr_r,
    output reg  [15:0] msi_data_r,
    input  wire        msi_ack
);

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_PWR  = 3'h2;
localparam [2:0] ST_ATT  = 3'h4;

// byte-enable merge of a 16-bit half under a write mask
function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  be;
    input [15:0] wmask;
    reg   [15:0] m;
    begin
        m = {{8{be[1]}}, {8{be[0]}}} & wmask;
        merge16 = (old & ~m) | (wd & m);
    end
endfunction

// dword hit decode
function hit;
    input [7:2] a;
    input [7:0] ofs;
    begin
        hit = (a == ofs[7:2]);
    end
endfunction

wire wr_slot = cfg_wr & hit(cfg_addr, `RPHP_OFS_SLOT_CONTROL);
wire wr_root = cfg_wr & hit(cfg_addr, `RPHP_OFS_ROOT_CONTROL);
wire wr_root_status = cfg_wr & hit(cfg_addr, `RPHP_OFS_ROOT_STATUS);
wire wr_msic = cfg_wr & hit(cfg_addr, `RPHP_OFS_MSI_CAP_HEADER);
wire wr_msia = cfg_wr & hit(cfg_addr, `RPHP_OFS_MSI_MSG_ADDRESS);
wire wr_msid = cfg_wr & hit(cfg_addr, `RPHP_OFS_MSI_MSG_DATA);
wire wr_ssid = cfg_wr & hit(cfg_addr, `RPHP_OFS_SUBSYSTEM_IDS);

// ------------------------------------------------------------
// state
// ------------------------------------------------------------
reg  [15:0] slot_control_r;
reg  [15:0] root_control_r;
reg  [15:0] msi_msg_control_r;
reg  [31:0] msi_msg_address_r;
reg  [15:0] msi_msg_data_r;
reg  [15:0] subsystem_id_r;
reg  [15:0] subsystem_vendor_id_r;
reg  [1:0]  ssid_lock_r;
reg         link_layer_active_r;
reg         link_active_q_r;
reg         slot_occupied_q_r;
reg         watch_r;
reg         link_active_changed_flag_r;
reg         command_completed_flag_r;
reg         presence_changed_flag_r;
reg         button_pressed_flag_r;
reg         pme_status_flag_r;
reg         pme_pending_flag_r;
reg  [15:0] pme_requester_id_r;
reg  [15:0] pme_pending_id_r;
reg  [2:0]  lamp_state_r;
reg         pwr_pend_r;
reg         att_pend_r;
reg         irq_q_r;

// ------------------------------------------------------------
// link-active and presence tracking
// ------------------------------------------------------------
wire slot_occupied_state = slot_implemented ? presence_detect : 1'b1;
wire link_chg = watch_r & (link_layer_active_r != link_active_q_r);
wire pres_chg = watch_r & (slot_occupied_state != slot_occupied_q_r);

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        link_layer_active_r <= 1'b0;
        link_active_q_r     <= 1'b0;
        slot_occupied_q_r   <= 1'b0;
        watch_r             <= 1'b0;
    end else begin
        link_layer_active_r <= dl_active_state;
        link_active_q_r     <= link_layer_active_r;
        slot_occupied_q_r   <= slot_occupied_state;
        watch_r             <= 1'b1;
    end
end

// ------------------------------------------------------------
// slot control and indicator messages
// ------------------------------------------------------------
wire [15:0] sc_wd    = cfg_wdata[15:0];
wire        pwr_wr   = wr_slot & cfg_be[1] & (sc_wd[`RPHP_SC_PWR_HI:`RPHP_SC_PWR_LO] != `RPHP_LAMP_RSVD);
wire        att_wr   = wr_slot & cfg_be[0] & (sc_wd[`RPHP_SC_ATT_HI:`RPHP_SC_ATT_LO] != `RPHP_LAMP_RSVD);
wire        msg_done = lamp_msg_valid_r & lamp_msg_ready;
wire        last_msg = msg_done & ~pwr_pend_r & ~att_pend_r & ~pwr_wr & ~att_wr;
reg  [15:0] sc_nxt;
reg  [2:0]  lamp_nxt;

always @* begin
    // reserved lamp codes are dropped, other bits stored as written under RPHP_SC_WMASK
    sc_nxt = merge16(slot_control_r, sc_wd, cfg_be[1:0], `RPHP_SC_WMASK);
    if (!pwr_wr)
        sc_nxt[`RPHP_SC_PWR_HI:`RPHP_SC_PWR_LO] = slot_control_r[`RPHP_SC_PWR_HI:`RPHP_SC_PWR_LO];
    if (!att_wr)
        sc_nxt[`RPHP_SC_ATT_HI:`RPHP_SC_ATT_LO] = slot_control_r[`RPHP_SC_ATT_HI:`RPHP_SC_ATT_LO];
    lamp_nxt = lamp_state_r;
    case (lamp_state_r)
        ST_IDLE: begin
            if (pwr_pend_r)
                lamp_nxt = ST_PWR;
            else if (att_pend_r)
                lamp_nxt = ST_ATT;
        end
        ST_PWR: begin
            if (msg_done)
                lamp_nxt = ST_IDLE;
        end
        ST_ATT: begin
            if (msg_done)
                lamp_nxt = ST_IDLE;
        end
        default: lamp_nxt = ST_IDLE;
    endcase
end

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        slot_control_r   <= `RPHP_RST_SLOT_CONTROL;
        lamp_state_r     <= ST_IDLE;
        pwr_pend_r       <= 1'b0;
        att_pend_r       <= 1'b0;
        lamp_msg_valid_r <= 1'b0;
        lamp_msg_sel_r   <= `RPHP_LAMP_SEL_PWR;
        lamp_msg_state_r <= `RPHP_LAMP_RSVD;
    end else begin
        if (wr_slot)
            slot_control_r <= sc_nxt;
        lamp_state_r <= lamp_nxt;
        if (pwr_wr)
            pwr_pend_r <= 1'b1;
        else if (lamp_state_r == ST_IDLE)
            pwr_pend_r <= 1'b0;
        if (att_wr)
            att_pend_r <= 1'b1;
        else if (lamp_state_r == ST_IDLE && !pwr_pend_r)
            att_pend_r <= 1'b0;
        if (lamp_state_r == ST_IDLE && (pwr_pend_r || att_pend_r)) begin
            lamp_msg_valid_r <= 1'b1;
            lamp_msg_sel_r   <= pwr_pend_r ? `RPHP_LAMP_SEL_PWR : `RPHP_LAMP_SEL_ATT;
            lamp_msg_state_r <= pwr_pend_r ? slot_control_r[`RPHP_SC_PWR_HI:`RPHP_SC_PWR_LO]
                                           : slot_control_r[`RPHP_SC_ATT_HI:`RPHP_SC_ATT_LO];
        end else if (msg_done) begin
            lamp_msg_valid_r <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// slot status flags, write-one-to-clear, set wins
// ------------------------------------------------------------
wire [15:0] ss_clr = (wr_slot ? cfg_wdata[31:16] & {{8{cfg_be[3]}}, {8{cfg_be[2]}}} : 16'h0000);

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        link_active_changed_flag_r <= 1'b0;
        command_completed_flag_r   <= 1'b0;
        presence_changed_flag_r    <= 1'b0;
        button_pressed_flag_r      <= 1'b0;
    end else begin
        link_active_changed_flag_r <= link_chg | (link_active_changed_flag_r & ~ss_clr[`RPHP_SS_LINK_ACTIVE_CHANGED_FLAG]);
        command_completed_flag_r   <= last_msg | (command_completed_flag_r & ~ss_clr[`RPHP_SS_CC]);
        presence_changed_flag_r    <= pres_chg | (presence_changed_flag_r & ~ss_clr[`RPHP_SS_PDC]);
        button_pressed_flag_r      <= button_press_evt | (button_pressed_flag_r & ~ss_clr[`RPHP_SS_ABP]);
    end
end

// ------------------------------------------------------------
// root control, pme status and pending
// ------------------------------------------------------------
wire ps_clr = wr_root_status & cfg_be[2] & cfg_wdata[`RPHP_RS_PS];

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        root_control_r     <= `RPHP_RST_ROOT_CONTROL;
        pme_status_flag_r  <= 1'b0;
        pme_pending_flag_r <= 1'b0;
        pme_requester_id_r <= 16'h0000;
        pme_pending_id_r   <= 16'h0000;
    end else begin
        if (wr_root)
            root_control_r <= merge16(root_control_r, cfg_wdata[15:0], cfg_be[1:0], `RPHP_RC_WMASK);
        if (pme_status_flag_r && !ps_clr) begin
            // one further pme waits behind the one shown; others arriving while it is pending are dropped
            if (pme_evt && !pme_pending_flag_r) begin
                pme_pending_flag_r <= 1'b1;
                pme_pending_id_r   <= pme_req_id;
            end
        end else if (pme_status_flag_r && pme_pending_flag_r) begin
            pme_requester_id_r <= pme_pending_id_r;
            pme_pending_flag_r <= pme_evt;
            pme_pending_id_r   <= pme_req_id;
        end else if (pme_evt) begin
            pme_status_flag_r  <= 1'b1;
            pme_requester_id_r <= pme_req_id;
        end else if (ps_clr) begin
            pme_status_flag_r  <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// system error
// ------------------------------------------------------------
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
        serr_r <= 1'b0;
    else
        serr_r <= serr_enable & ((err_fatal_evt    & root_control_r[`RPHP_RC_SFE]) |
                                 (err_nonfatal_evt & root_control_r[`RPHP_RC_SNE]) |
                                 (err_corr_evt     & root_control_r[`RPHP_RC_SCE]));
end

// ------------------------------------------------------------
// msi registers and subsystem ids
// ------------------------------------------------------------
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        msi_msg_control_r     <= 16'h0000;
        msi_msg_address_r     <= `RPHP_RST_MSI_ADDRESS;
        msi_msg_data_r        <= 16'h0000;
        subsystem_id_r        <= 16'h0000;
        subsystem_vendor_id_r <= 16'h0000;
        ssid_lock_r           <= 2'b00;
    end else begin
        if (wr_msic)
            msi_msg_control_r <= merge16(msi_msg_control_r, cfg_wdata[31:16], cfg_be[3:2], `RPHP_MC_WMASK);
        if (wr_msia) begin
            msi_msg_address_r[31:16] <= merge16(msi_msg_address_r[31:16], cfg_wdata[31:16], cfg_be[3:2], 16'hFFFF);
            msi_msg_address_r[15:0]  <= merge16(msi_msg_address_r[15:0], cfg_wdata[15:0], cfg_be[1:0], 16'hFFFC);
        end
        if (wr_msid)
            msi_msg_data_r <= merge16(msi_msg_data_r, cfg_wdata[15:0], cfg_be[1:0], 16'hFFFF);
        // arst_n is the bridge reset; secondary bus reset never reaches here
        if (wr_ssid && !ssid_lock_r[1] && |cfg_be[3:2]) begin
            subsystem_id_r <= merge16(subsystem_id_r, cfg_wdata[31:16], cfg_be[3:2], 16'hFFFF);
            ssid_lock_r[1] <= 1'b1;
        end
        if (wr_ssid && !ssid_lock_r[0] && |cfg_be[1:0]) begin
            subsystem_vendor_id_r <= merge16(subsystem_vendor_id_r, cfg_wdata[15:0], cfg_be[1:0], 16'hFFFF);
            ssid_lock_r[0]        <= 1'b1;
        end
    end
end

// ------------------------------------------------------------
// interrupt generation and delivery
// ------------------------------------------------------------
wire hp_irq = slot_control_r[`RPHP_SC_HPE] &
              ((slot_control_r[`RPHP_SC_LINK_ACTIVE_CHANGE_IRQ_ENABLE] & link_active_changed_flag_r) |
               (slot_control_r[`RPHP_SC_CCE]  & command_completed_flag_r)   |
               (slot_control_r[`RPHP_SC_PDE]  & presence_changed_flag_r)    |
               (slot_control_r[`RPHP_SC_ABE]  & button_pressed_flag_r));
wire pme_irq = root_control_r[`RPHP_RC_PIE] & pme_status_flag_r;
wire irq_req = hp_irq | pme_irq;
wire msi_on  = msi_msg_control_r[`RPHP_MC_EN];

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        irq_q_r    <= 1'b0;
        intx_r     <= 1'b0;
        msi_req_r  <= 1'b0;
        msi_addr_r <= 32'h00000000;
        msi_data_r <= 16'h0000;
    end else begin
        irq_q_r <= irq_req;
        intx_r  <= irq_req & ~msi_on;
        if (irq_req && !irq_q_r && msi_on && bus_master_enable && !msi_req_r) begin
            msi_req_r  <= 1'b1;
            msi_addr_r <= {msi_msg_address_r[31:2], 2'b00};
            msi_data_r <= msi_msg_data_r;
        end else if (msi_ack) begin
            msi_req_r <= 1'b0;
        end
    end
end

// ------------------------------------------------------------
// read path
// ------------------------------------------------------------
reg [31:0] rd_nxt;

always @* begin
    rd_nxt = 32'h00000000;
    case (cfg_addr)
        `RPHP_OFS_SLOT_CONTROL >> 2: begin
            rd_nxt[15:0] = slot_control_r;
            rd_nxt[16 + `RPHP_SS_LINK_ACTIVE_CHANGED_FLAG] = link_active_changed_flag_r;
            rd_nxt[16 + `RPHP_SS_PDS]  = slot_occupied_state;
            rd_nxt[16 + `RPHP_SS_CC]   = command_completed_flag_r;
            rd_nxt[16 + `RPHP_SS_PDC]  = presence_changed_flag_r;
            rd_nxt[16 + `RPHP_SS_ABP]  = button_pressed_flag_r;
        end
        `RPHP_OFS_ROOT_CONTROL >> 2:   rd_nxt[15:0] = root_control_r;
        `RPHP_OFS_ROOT_STATUS >> 2:
            rd_nxt = {14'h0000, pme_pending_flag_r, pme_status_flag_r, pme_requester_id_r};
        `RPHP_OFS_MSI_CAP_HEADER >> 2: rd_nxt = {msi_msg_control_r, `RPHP_VAL_MSI_CAP_HEADER};
        `RPHP_OFS_MSI_MSG_ADDRESS >> 2: rd_nxt = {msi_msg_address_r[31:2], 2'b00};
        `RPHP_OFS_MSI_MSG_DATA >> 2:   rd_nxt[15:0] = msi_msg_data_r;
        `RPHP_OFS_SUBSYS_CAP_HDR >> 2: rd_nxt[15:0] = `RPHP_VAL_SUBSYS_CAP_HDR;
        `RPHP_OFS_SUBSYSTEM_IDS >> 2:  rd_nxt = {subsystem_id_r, subsystem_vendor_id_r};
        `RPHP_OFS_PM_CAP_HEADER >> 2:  rd_nxt = {`RPHP_VAL_PM_CAPS, `RPHP_VAL_PM_CAP_HEADER};
        default:                       rd_nxt = 32'h00000000;
    endcase
end

always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        cfg_rdata_r    <= 32'h00000000;
        cfg_rd_valid_r <= 1'b0;
    end else begin
        cfg_rd_valid_r <= cfg_rd;
        if (cfg_rd)
            cfg_rdata_r <= rd_nxt;
    end
end

endmodule
